// >>> common/cbu_defs.vh
// constants for the conditional branch unit
`ifndef CBU_DEFS_VH
`define CBU_DEFS_VH

// ****************************************
// opcode upper bytes
// ****************************************
`define CBU_OP_BRANCH_IF_NEGATIVE       8'hE6
`define CBU_OP_BRANCH_IF_CARRY_CLEAR    8'hE3
`define CBU_OP_BRANCH_IF_NEGATIVE_CLEAR 8'hE7
`define CBU_OP_BRANCH_IF_OVERFLOW_CLEAR 8'hE5

// ****************************************
// phases and widths
// ****************************************
`define CBU_Q1          2'h0
`define CBU_Q2          2'h1
`define CBU_Q3          2'h2
`define CBU_Q4          2'h3
`define CBU_PC_STEP     2
`define CBU_PC_WIDTH    21

`endif

// >>> verilog/cbu_decode.v
// opcode decode and flag test for the conditional branches
`timescale 1ns/1ps
`include "cbu_defs.vh"

module cbu_decode (
    // instruction and flags
    input  wire [15:0] instr,
    input  wire        flag_negative,
    input  wire        flag_carry,
    input  wire        flag_overflow,
    // result
    output reg         is_branch,
    output reg         take
);

    // ****************************************
    // decode
    // ****************************************
    always @* begin
        is_branch = 1'b1;
        take      = 1'b0;
        case (instr[15:8])
            `CBU_OP_BRANCH_IF_NEGATIVE:       take = flag_negative;   // [RULE_01]
            `CBU_OP_BRANCH_IF_CARRY_CLEAR:    take = ~flag_carry;     // [RULE_02]
            `CBU_OP_BRANCH_IF_NEGATIVE_CLEAR: take = ~flag_negative;  // [RULE_03]
            `CBU_OP_BRANCH_IF_OVERFLOW_CLEAR: take = ~flag_overflow;  // [RULE_04]
            default: is_branch = 1'b0;
        endcase
    end

endmodule // cbu_decode

// >>> verilog/cbu_branch_unit.v
// conditional relative branch execution unit
`timescale 1ns/1ps
`include "cbu_defs.vh"
// Functional notes
// [RULE_01] upper byte E6 is branch-if-negative, taken when negative is one.
// [RULE_02] upper byte E3 is branch-if-carry-clear, taken when carry is zero.
// [RULE_03] upper byte E7 is branch-if-negative-clear, taken when negative zero.
// [RULE_04] upper byte E5 is branch-if-overflow-clear, taken when overflow zero.
// [RULE_05] the low byte is a signed offset -128..127 and is doubled.
// [RULE_06] a taken branch loads pc with own address plus two plus twice offset.
// [RULE_07] the target uses the already advanced pc; not taken falls through.
// [RULE_08] one word; one cycle not taken, two cycles taken.
// [RULE_09] taken: decode Q1, literal Q2, process Q3, pc write Q4, then a nop cycle.
// [RULE_10] no status flag is changed by these branches.

module cbu_branch_unit #(
    parameter PC_WIDTH = `CBU_PC_WIDTH
) (
    // clock and reset
    input  wire                sys_clk,
    input  wire                rst_n,
    // instruction cycle
    input  wire                instr_valid,
    input  wire [15:0]         instr,
    input  wire [PC_WIDTH-1:0] pc_advanced,
    // status flags, read only
    input  wire                flag_negative,
    input  wire                flag_carry,
    input  wire                flag_overflow,
    // results
    output reg  [1:0]          q_phase,
    output reg                 busy,
    output reg                 nop_cycle,
    output reg                 pc_write,
    output reg  [PC_WIDTH-1:0] pc_target,
    output reg                 branch_done,
    output reg                 branch_taken
);

    // ****************************************
    // state
    // ****************************************
    localparam ST_IDLE = 2'b00;
    localparam ST_EXEC = 2'b01;
    localparam ST_NOP  = 2'b10;

    reg  [1:0]          state;
    reg  [1:0]          next_state;
    reg                 take_latched;
    reg  [7:0]          offset;
    // pc base held from accept so a moving fetch pc cannot skew the target
    reg  [PC_WIDTH-1:0] pc_base;
    reg  [PC_WIDTH-1:0] target_calc;
    wire                is_branch;
    wire                take;

    cbu_decode u_decode (
        .instr         (instr),
        .flag_negative (flag_negative),
        .flag_carry    (flag_carry),
        .flag_overflow (flag_overflow),
        .is_branch     (is_branch),
        .take          (take)
    );

    // ****************************************
    // phase counter and sequence
    // ****************************************
    // flags are only inputs; nothing here writes them [RULE_10]
    always @* begin
        case (state)
            ST_IDLE: begin
                if (instr_valid && is_branch && q_phase == `CBU_Q4)
                    next_state = ST_EXEC;
                else
                    next_state = ST_IDLE;
            end
            ST_EXEC: begin
                if (q_phase == `CBU_Q4)
                    next_state = take_latched ? ST_NOP : ST_IDLE; // [RULE_08]
                else
                    next_state = ST_EXEC;
            end
            ST_NOP: begin
                next_state = (q_phase == `CBU_Q4) ? ST_IDLE : ST_NOP;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // pc + 2 is already applied upstream; offset doubled [RULE_05] [RULE_07]
    always @* begin
        target_calc = pc_base +
            {{(PC_WIDTH-9){offset[7]}}, offset, 1'b0}; // [RULE_06]
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_phase      <= `CBU_Q1;
            state        <= ST_IDLE;
            take_latched <= 1'b0;
            offset       <= 8'h00;
            pc_base      <= {PC_WIDTH{1'b0}};
            busy         <= 1'b0;
            nop_cycle    <= 1'b0;
            pc_write     <= 1'b0;
            pc_target    <= {PC_WIDTH{1'b0}};
            branch_done  <= 1'b0;
            branch_taken <= 1'b0;
        end else begin
            q_phase     <= q_phase + 2'h1;
            state       <= next_state;
            pc_write    <= 1'b0;
            branch_done <= 1'b0;
            // instruction taken at end of prior Q4, held until the next accepted branch
            if (state == ST_IDLE && next_state == ST_EXEC) begin
                take_latched <= take;             // decode in Q1 [RULE_09]
                offset       <= instr[7:0];       // literal read [RULE_09]
                pc_base      <= pc_advanced;      // [RULE_07]
            end
            busy      <= (next_state != ST_IDLE);
            nop_cycle <= (next_state == ST_NOP);  // [RULE_09]
            // process in Q3, pc write strobe in Q4
            if (state == ST_EXEC && q_phase == `CBU_Q3 && take_latched) begin
                pc_target <= target_calc;         // [RULE_06]
                pc_write  <= 1'b1;                // [RULE_09]
            end
            if (state == ST_EXEC && q_phase == `CBU_Q3) begin
                branch_done  <= 1'b1;
                branch_taken <= take_latched;
            end
        end
    end

endmodule // cbu_branch_unit

// >>> verification/cbu_branch_unit_properties.sv
// assertion checker for the conditional branch unit
`timescale 1ns/1ps
module cbu_checker #(
    parameter PC_WIDTH = 21
) (
    // clock and reset
    input wire                sys_clk,
    input wire                rst_n,
    // inputs
    input wire                instr_valid,
    input wire [15:0]         instr,
    input wire [PC_WIDTH-1:0] pc_advanced,
    input wire                flag_negative,
    input wire                flag_carry,
    input wire                flag_overflow,
    // outputs
    input wire [1:0]          q_phase,
    input wire                busy,
    input wire                nop_cycle,
    input wire                pc_write,
    input wire [PC_WIDTH-1:0] pc_target,
    input wire                branch_done,
    input wire                branch_taken
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // busy excluded so a late accept cannot fire these
    wire       acc = q_phase == 2'h3 && instr_valid && !busy;
    wire [7:0] op  = instr[15:8];
    sequence s_exec; busy [*3] ##1 branch_done; endsequence
    sequence s_idle; nop_cycle [*4] ##1 !busy; endsequence
    AST_NEG: assert property (acc && op == 8'hE6 |-> ##4
        pc_write == $past(flag_negative, 4)) else $error("neg branch");
    AST_NCY: assert property (acc && op == 8'hE3 |-> ##4
        pc_write == !$past(flag_carry, 4)) else $error("carry branch");
    AST_NNG: assert property (acc && op == 8'hE7 |-> ##4
        pc_write == !$past(flag_negative, 4)) else $error("nneg branch");
    AST_NOV: assert property (acc && op == 8'hE5 |-> ##4
        pc_write == !$past(flag_overflow, 4)) else $error("ovf branch");
    AST_EXEC: assert property (acc && (op == 8'hE6 || op == 8'hE3 ||
        op == 8'hE7 || op == 8'hE5) |=> s_exec) else $error("exec cycle");
    AST_TGT: assert property (pc_write |-> pc_target ==
        $past(pc_advanced, 4) + ({{(PC_WIDTH-8){$past(instr[7], 4)}},
        $past(instr[7:0], 4)} << 1)) else $error("target");
    AST_IDLE: assert property (pc_write |=> s_idle)
        else $error("idle cycle");
    AST_FALL: assert property (branch_done && !pc_write |=> !busy)
        else $error("fall through");
    AST_Q4: assert property (pc_write |-> q_phase == 2'h3 &&
        branch_taken && branch_done) else $error("pc write phase");
endmodule // cbu_checker
bind cbu_branch_unit cbu_checker #(.PC_WIDTH(PC_WIDTH)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .pc_advanced(pc_advanced), .flag_negative(flag_negative),
    .flag_carry(flag_carry), .flag_overflow(flag_overflow),
    .q_phase(q_phase), .busy(busy), .nop_cycle(nop_cycle),
    .pc_write(pc_write), .pc_target(pc_target), .branch_done(branch_done),
    .branch_taken(branch_taken));

// >>> verification/cbu_branch_unit_test.sv
// self-checking bench for the conditional branch unit
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin \
    error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module cbu_branch_unit_test;
    reg         sys_clk = 0, rst_n = 0, instr_valid = 0;
    reg  [15:0] instr = 16'h0000;
    reg  [20:0] pc_advanced = 21'h000000;
    reg         flag_negative = 0, flag_carry = 0, flag_overflow = 0;
    wire [1:0]  q_phase;
    wire [20:0] pc_target;
    wire        busy, nop_cycle, pc_write, branch_done, branch_taken;
    integer     error_cnt = 0, n_compared = 0, i, k;
    reg  [40:0] rows [0:9];
    cbu_branch_unit uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr(instr), .pc_advanced(pc_advanced),
        .flag_negative(flag_negative), .flag_carry(flag_carry),
        .flag_overflow(flag_overflow), .q_phase(q_phase), .busy(busy),
        .nop_cycle(nop_cycle), .pc_write(pc_write), .pc_target(pc_target),
        .branch_done(branch_done), .branch_taken(branch_taken));
    always #12.5 sys_clk = ~sys_clk;
    task complete_run;
        begin
            $display("compared %0d errors %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // waits for an idle Q4 so busy never overlaps the request
    task run(input [40:0] r);
        begin
            @(negedge sys_clk);
            while (q_phase !== 2'h3 || busy !== 1'b0) @(negedge sys_clk);
            {instr, flag_negative, flag_carry, flag_overflow} = r[40:22];
            pc_advanced = r[21:1];
            instr_valid = 1;
            @(negedge sys_clk);
            instr_valid = 0;
            k = 0;
            while (branch_done !== 1'b1 && k < 8) begin
                @(negedge sys_clk);
                k++;
            end
        end
    endtask
    initial begin #50000; error_cnt++; complete_run; end
    initial begin
        // instr, n c v, pc advanced, taken
        rows[0] = {16'hE605, 3'b100, 21'h000100, 1'b1};
        rows[1] = {16'hE605, 3'b000, 21'h000100, 1'b0};
        rows[2] = {16'hE380, 3'b000, 21'h000400, 1'b1};
        rows[3] = {16'hE380, 3'b010, 21'h000400, 1'b0};
        rows[4] = {16'hE77F, 3'b000, 21'h1FFFFE, 1'b1};
        rows[5] = {16'hE77F, 3'b100, 21'h000200, 1'b0};
        rows[6] = {16'hE5FF, 3'b000, 21'h000010, 1'b1};
        rows[7] = {16'hE5FF, 3'b001, 21'h000010, 1'b0};
        rows[8] = {16'hE601, 3'b011, 21'h000020, 1'b0};
        rows[9] = {16'h1234, 3'b000, 21'h000100, 1'b0};
        repeat (4) @(negedge sys_clk);
        `CHK("reset busy", 1'b0, busy);
        rst_n = 1;
        @(negedge sys_clk);
        `CHK("phase", 2'h1, q_phase);
        for (i = 0; i < 9; i++) begin
            run(rows[i]);
            `CHK("done", 1'b1, branch_done);
            `CHK("taken", rows[i][0], branch_taken);
            `CHK("pc write", rows[i][0], pc_write);
            if (rows[i][0]) `CHK("target", pc_advanced +
                {{12{instr[7]}}, instr[7:0], 1'b0}, pc_target);
            @(negedge sys_clk);
            `CHK("nop", rows[i][0], nop_cycle);
            `CHK("busy", rows[i][0], busy);
        end
        run(rows[9]);
        `CHK("other opcode", 1'b0, branch_done);
        run(rows[0]);
        rst_n = 0;
        #1 `CHK("midrun busy", 1'b0, busy);
        @(negedge sys_clk) rst_n = 1;
        @(negedge sys_clk);
        `CHK("phase after reset", 2'h1, q_phase);
        run(rows[2]);
        `CHK("taken after reset", 1'b1, branch_taken);
        `CHK("target after reset", 21'h000300, pc_target);
        complete_run;
    end
endmodule // cbu_branch_unit_test
